// [dscr_loader_model.sv]
// Behavioural EEPROM loader facing the load port of the register bank.
// Assumes one load_start pulse per attempt; present_in says whether a part answers.
`timescale 1ns/1ns
`default_nettype none
module dscr_loader_model (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // Control
    input  wire logic        load_start_in,
    input  wire logic        present_in,
    input  wire logic [15:0] word_in,
    // Load port
    output var  logic [7:0]  load_code_out,
    output var  logic        load_write_out,
    output var  logic [15:0] load_wdata_out,
    output var  logic        load_busy_out,
    output var  logic        load_done_out
);
    logic [2:0] step;
    wire  [2:0] next_step = load_start_in ? 3'h1 : (step == 3'h0 || step == 3'h6) ? 3'h0 : step + 3'h1;
    wire        next_wr   = present_in && (next_step == 3'h2 || next_step == 3'h3);
    // An absent part still costs a busy attempt; released lines toggle so stale data never looks valid.
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            step <= 3'h0;
            load_code_out <= 8'h00;
            load_write_out <= 1'b0;
            load_wdata_out <= 16'h0000;
            load_busy_out <= 1'b0;
            load_done_out <= 1'b0;
        end else begin
            step <= next_step;
            load_busy_out <= next_step != 3'h0;
            load_write_out <= next_wr;
            load_code_out <= next_wr ? (next_step == 3'h2 ? 8'h10 : 8'h1E) : ~load_code_out;
            load_wdata_out <= next_wr ? (next_step == 3'h2 ? word_in : 16'h0055) : ~load_wdata_out;
            load_done_out <= present_in && next_step == 3'h6;
        end
    end
endmodule
`default_nettype wire

// [dscr_pkg.sv]
// Package for the driver system configuration register bank.
// Assumes a 16-bit register word reached by an 8-bit command code.
package dscr_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned CMD_W  = 8;
    localparam int unsigned IDX_W  = 5;

    // Command codes.
    localparam logic [7:0] CMD_BIAS_DAC     = 8'h01;
    localparam logic [7:0] CMD_MOD_DAC      = 8'h02;
    localparam logic [7:0] CMD_PWR_LIM_DAC  = 8'h03;
    localparam logic [7:0] CMD_INT_TEMP     = 8'h05;
    localparam logic [7:0] CMD_MOD_READ     = 8'h06;
    localparam logic [7:0] CMD_BIAS_READ    = 8'h07;
    localparam logic [7:0] CMD_FACTORY_TEST = 8'h08;
    localparam logic [7:0] CMD_EXT_TEMP     = 8'h0D;
    localparam logic [7:0] CMD_SYSTEM_CONFIGURATION   = 8'h10;
    localparam logic [7:0] CMD_BIAS_CEIL    = 8'h11;
    localparam logic [7:0] CMD_FAULT_FLAGS  = 8'h12;
    localparam logic [7:0] CMD_FAULT_CFG    = 8'h13;
    localparam logic [7:0] CMD_BIAS_NOM     = 8'h15;
    localparam logic [7:0] CMD_BIAS_TC1     = 8'h16;
    localparam logic [7:0] CMD_BIAS_TC2     = 8'h17;
    localparam logic [7:0] CMD_USER_CONV    = 8'h18;
    localparam logic [7:0] CMD_MOD_NOM      = 8'h19;
    localparam logic [7:0] CMD_MOD_TC1      = 8'h1A;
    localparam logic [7:0] CMD_MOD_TC2      = 8'h1B;
    localparam logic [7:0] CMD_NOM_TEMP     = 8'h1D;
    localparam logic [7:0] CMD_LOOP_GAIN    = 8'h1E;
    localparam logic [7:0] CMD_PEAKING      = 8'h1F;

    // System configuration field positions.
    localparam int unsigned SC_CTRL_SRC  = 0;
    localparam int unsigned SC_SOFT_EN   = 1;
    localparam int unsigned SC_EN_POL    = 2;
    localparam int unsigned SC_APC       = 3;
    localparam int unsigned SC_PWR_DOWN  = 4;
    localparam int unsigned SC_EXT_TEMP  = 5;
    localparam int unsigned SC_PD_ORIENT = 6;
    localparam int unsigned SC_CML_TERM  = 7;

    // Reset values and the writable field mask.
    localparam logic [15:0] SC_RESET     = 16'h0010;
    localparam logic [15:0] SC_WR_MASK   = 16'h00FF;
    localparam logic [15:0] LOOP_RESET   = 16'h0021;
    localparam logic [15:0] PEAK_RESET   = 16'h0010;
    localparam logic [15:0] OTHER_RESET  = 16'h0000;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;

    // EEPROM load retry interval.
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned RETRY_MS       = 64;
    localparam int unsigned RETRY_CYCLES   = (CLK_HZ / 1000) * RETRY_MS;

endpackage

// [dscr_regs.sv]
// Register bank and system configuration logic of the laser driver controller.
// Assumes a serial front end that turns bus transactions into command-code
// strobes, and an EEPROM loader that writes registers through the load port.
`timescale 1ns/1ns
`default_nettype none
module dscr_regs #(
    parameter int unsigned RETRY_INTERVAL = dscr_pkg::RETRY_CYCLES
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // Serial command port from the bus front end
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic        cmd_write_in,
    input  wire logic        cmd_read_in,
    input  wire logic [15:0] cmd_wdata_in,
    output logic      [15:0] cmd_rdata_out,
    output logic             cmd_ack_out,
    output logic             cmd_nack_out,
    // EEPROM loader port
    input  wire logic [7:0]  load_code_in,
    input  wire logic        load_write_in,
    input  wire logic [15:0] load_wdata_in,
    input  wire logic        load_busy_in,
    input  wire logic        load_done_in,
    output logic             load_start_out,
    output logic             loaded_out,
    // Pins and read-only sources
    input  wire logic        tx_enable_pin_in,
    input  wire logic [15:0] fault_flags_in,
    input  wire logic [15:0] power_limit_in,
    // Configuration outputs
    output logic             external_control_out,
    output logic             tx_enable_out,
    output logic             hs_amp_off_out,
    output logic             apc_mode_out,
    output logic             ext_temp_sel_out,
    output logic             photodiode_orientation_out,
    output logic             cml_term_out,
    output logic      [15:0] comp_temperature_out
);

    localparam int unsigned N_REGS = 32;

    // Stored registers, indexed by the low five command bits.
    logic [15:0] regs [N_REGS];
    logic [15:0] system_configuration;
    logic        pin_sync;
    logic        retry_start;
    logic        retry_loaded;

    function automatic logic is_stored(input logic [7:0] code);
        is_stored = (code == dscr_pkg::CMD_BIAS_DAC)     || (code == dscr_pkg::CMD_MOD_DAC)
                 || (code == dscr_pkg::CMD_INT_TEMP)     || (code == dscr_pkg::CMD_MOD_READ)
                 || (code == dscr_pkg::CMD_BIAS_READ)    || (code == dscr_pkg::CMD_FACTORY_TEST)
                 || (code == dscr_pkg::CMD_EXT_TEMP)     || (code == dscr_pkg::CMD_BIAS_CEIL)
                 || (code == dscr_pkg::CMD_FAULT_CFG)    || (code == dscr_pkg::CMD_BIAS_NOM)
                 || (code == dscr_pkg::CMD_BIAS_TC1)     || (code == dscr_pkg::CMD_BIAS_TC2)
                 || (code == dscr_pkg::CMD_USER_CONV)    || (code == dscr_pkg::CMD_MOD_NOM)
                 || (code == dscr_pkg::CMD_MOD_TC1)      || (code == dscr_pkg::CMD_MOD_TC2)
                 || (code == dscr_pkg::CMD_NOM_TEMP)     || (code == dscr_pkg::CMD_LOOP_GAIN)
                 || (code == dscr_pkg::CMD_PEAKING);
    endfunction

    function automatic logic is_read_only(input logic [7:0] code);
        is_read_only = (code == dscr_pkg::CMD_FAULT_FLAGS) || (code == dscr_pkg::CMD_PWR_LIM_DAC);
    endfunction

    function automatic logic [15:0] reset_of(input int unsigned idx);
        if (idx == int'(dscr_pkg::CMD_LOOP_GAIN)) begin
            reset_of = dscr_pkg::LOOP_RESET;
        end else if (idx == int'(dscr_pkg::CMD_PEAKING)) begin
            reset_of = dscr_pkg::PEAK_RESET;
        end else begin
            reset_of = dscr_pkg::OTHER_RESET;
        end
    endfunction

    // Pin synchroniser and load retry timer.
    dscr_sync #(
        .WIDTH (1)
    ) u_pin_sync (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .async_in (tx_enable_pin_in),
        .sync_out (pin_sync)
    );

    wire standalone = !system_configuration[dscr_pkg::SC_CTRL_SRC];

    dscr_retry #(
        .INTERVAL (RETRY_INTERVAL)
    ) u_retry (
        .clock_in       (clock_in),
        .nrst_in        (nrst_in),
        .standalone_in  (standalone),
        .load_done_in   (load_done_in),
        .load_start_out (retry_start),
        .loaded_out     (retry_loaded)
    );

    // Host access decode.
    wire host_access  = cmd_write_in || cmd_read_in;
    wire host_mapped  = is_stored(cmd_code_in) || is_read_only(cmd_code_in)
                     || (cmd_code_in == dscr_pkg::CMD_SYSTEM_CONFIGURATION);
    // A host access that lands on a running EEPROM load is refused, as on a bus collision.
    wire host_refuse  = !host_mapped || load_busy_in
                     || (cmd_write_in && is_read_only(cmd_code_in));
    wire host_wr      = cmd_write_in && !host_refuse;
    wire host_rd      = cmd_read_in && !cmd_write_in && !host_refuse;

    // The loader may only write while the device runs standalone.
    wire load_wr      = load_write_in && standalone && !host_wr;
    wire load_mapped  = is_stored(load_code_in) || (load_code_in == dscr_pkg::CMD_SYSTEM_CONFIGURATION);

    wire [7:0]  wr_code  = host_wr ? cmd_code_in : load_code_in;
    wire [15:0] wr_data  = host_wr ? cmd_wdata_in : load_wdata_in;
    wire        wr_en    = host_wr || (load_wr && load_mapped);
    wire [4:0]  wr_idx   = wr_code[4:0];
    wire [4:0]  rd_idx   = cmd_code_in[4:0];

    wire sc_write = wr_en && (wr_code == dscr_pkg::CMD_SYSTEM_CONFIGURATION);
    wire [15:0] next_system_configuration = wr_data & dscr_pkg::SC_WR_MASK;

    wire [15:0] rd_word =
        (cmd_code_in == dscr_pkg::CMD_SYSTEM_CONFIGURATION)  ? system_configuration :
        (cmd_code_in == dscr_pkg::CMD_FAULT_FLAGS) ? fault_flags_in :
        (cmd_code_in == dscr_pkg::CMD_PWR_LIM_DAC) ? power_limit_in :
        regs[rd_idx];

    // Transmitter enable: pin read through its polarity, then gated by software.
    wire pin_active = system_configuration[dscr_pkg::SC_EN_POL] ? pin_sync : !pin_sync;
    wire tx_on      = pin_active && system_configuration[dscr_pkg::SC_SOFT_EN];
    wire amp_off    = system_configuration[dscr_pkg::SC_PWR_DOWN] && !tx_on;
    wire [15:0] next_temperature = system_configuration[dscr_pkg::SC_EXT_TEMP]
                                 ? regs[dscr_pkg::CMD_EXT_TEMP[4:0]]
                                 : regs[dscr_pkg::CMD_INT_TEMP[4:0]];

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            system_configuration <= dscr_pkg::SC_RESET;
        end else if (sc_write) begin
            system_configuration <= next_system_configuration;
        end
    end

    for (genvar g = 0; g < N_REGS; g++) begin : g_reg
        always_ff @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
                regs[g] <= reset_of(g);
            end else if (wr_en && (wr_idx == 5'(g)) && is_stored(wr_code)) begin
                regs[g] <= wr_data;
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_rdata_out <= dscr_pkg::ZERO_WORD;
            cmd_ack_out   <= 1'b0;
            cmd_nack_out  <= 1'b0;
        end else begin
            cmd_ack_out  <= host_wr || host_rd;
            cmd_nack_out <= host_access && host_refuse;
            if (host_rd) begin
                cmd_rdata_out <= rd_word;
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            load_start_out             <= 1'b0;
            loaded_out                 <= 1'b0;
            external_control_out       <= 1'b0;
            tx_enable_out              <= 1'b0;
            hs_amp_off_out             <= 1'b0;
            apc_mode_out               <= 1'b0;
            ext_temp_sel_out           <= 1'b0;
            photodiode_orientation_out <= 1'b0;
            cml_term_out               <= 1'b0;
            comp_temperature_out       <= dscr_pkg::ZERO_WORD;
        end else begin
            load_start_out             <= retry_start && standalone;
            loaded_out                 <= retry_loaded;
            external_control_out       <= !standalone;
            tx_enable_out              <= tx_on;
            hs_amp_off_out             <= amp_off;
            apc_mode_out               <= system_configuration[dscr_pkg::SC_APC];
            ext_temp_sel_out           <= system_configuration[dscr_pkg::SC_EXT_TEMP];
            photodiode_orientation_out <= system_configuration[dscr_pkg::SC_PD_ORIENT];
            cml_term_out               <= system_configuration[dscr_pkg::SC_CML_TERM];
            comp_temperature_out       <= next_temperature;
        end
    end

endmodule
`default_nettype wire

// [dscr_regs_properties.sv]
// Concurrent checks on the ports of the register bank.
// Assumes one clock domain and the port names of dscr_regs.
`timescale 1ns/1ns
`default_nettype none
module dscr_regs_props #(
    parameter int unsigned RETRY_INTERVAL = 20
) (
    input wire logic        clock_in,
    input wire logic        nrst_in,
    input wire logic [7:0]  cmd_code_in,
    input wire logic        cmd_write_in,
    input wire logic        cmd_read_in,
    input wire logic [15:0] cmd_wdata_in,
    input wire logic [15:0] cmd_rdata_out,
    input wire logic        cmd_ack_out,
    input wire logic        cmd_nack_out,
    input wire logic        load_busy_in,
    input wire logic        load_done_in,
    input wire logic        load_start_out,
    input wire logic        loaded_out,
    input wire logic [15:0] fault_flags_in,
    input wire logic        external_control_out,
    input wire logic        tx_enable_out,
    input wire logic        hs_amp_off_out,
    input wire logic        apc_mode_out,
    input wire logic        ext_temp_sel_out,
    input wire logic        photodiode_orientation_out,
    input wire logic        cml_term_out,
    input wire logic [15:0] comp_temperature_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // The first pulse after reset has no predecessor, so only later gaps are judged.
    logic [31:0] gap;
    logic        seen;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap  <= 32'h0;
            seen <= 1'b0;
        end else begin
            gap  <= load_start_out ? 32'h1 : gap + 32'h1;
            seen <= (seen | load_start_out) & ~external_control_out;
        end
    end
    sequence cfg_wr;
        cmd_write_in && cmd_code_in == 8'h10 && !load_busy_in;
    endsequence
    sequence int_wr;
        cmd_write_in && cmd_code_in == 8'h05 && !load_busy_in && !ext_temp_sel_out ##1 !ext_temp_sel_out;
    endsequence
    a_cfg_write_ack: assert property (cfg_wr |=> cmd_ack_out && !cmd_nack_out)
        else $error("config write not acked");
    a_ro_write_nack: assert property (cmd_write_in && (cmd_code_in == 8'h12 || cmd_code_in == 8'h03)
        |=> cmd_nack_out && !cmd_ack_out) else $error("read-only write not refused");
    a_busy_refused: assert property (load_busy_in && (cmd_write_in || cmd_read_in) |=> cmd_nack_out)
        else $error("access during load not refused");
    a_fault_read: assert property (cmd_read_in && !cmd_write_in && cmd_code_in == 8'h12 && !load_busy_in
        |=> cmd_ack_out && cmd_rdata_out == $past(fault_flags_in)) else $error("fault read wrong");
    a_cfg_upper_zero: assert property (cmd_read_in && !cmd_write_in && cmd_code_in == 8'h10 && !load_busy_in
        |=> cmd_rdata_out[15:8] == 8'h00) else $error("config upper bits not zero");
    a_ctrl_src_follow: assert property (cfg_wr |-> ##2 external_control_out == $past(cmd_wdata_in[0], 2))
        else $error("control source not followed");
    a_mode_bits_follow: assert property (cfg_wr |-> ##2 {cml_term_out, photodiode_orientation_out,
        ext_temp_sel_out, apc_mode_out} == {$past(cmd_wdata_in[7:5], 2), $past(cmd_wdata_in[3], 2)})
        else $error("mode outputs not followed");
    a_comp_temp_int: assert property (int_wr |=> comp_temperature_out == $past(cmd_wdata_in, 2))
        else $error("internal temperature not selected");
    a_tx_amp_excl: assert property (tx_enable_out |-> !hs_amp_off_out)
        else $error("amplifiers off while transmitting");
    a_ext_no_load: assert property (external_control_out && $past(external_control_out) |-> !load_start_out)
        else $error("load attempt under external control");
    a_retry_gap: assert property (load_start_out && seen |-> gap == RETRY_INTERVAL)
        else $error("retry interval wrong");
    a_done_loaded: assert property (load_done_in |-> ##2 loaded_out)
        else $error("loaded flag missing");
endmodule
bind dscr_regs dscr_regs_props #(.RETRY_INTERVAL(RETRY_INTERVAL)) u_props (.*);
`default_nettype wire

// [dscr_retry.sv]
// EEPROM load retry timer: requests a load now and then every interval.
// Assumes the loader reports success with a one-cycle done pulse.
`timescale 1ns/1ns
`default_nettype none
module dscr_retry #(
    parameter int unsigned INTERVAL = dscr_pkg::RETRY_CYCLES
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic nrst_in,
    // Control
    input  wire logic standalone_in,
    input  wire logic load_done_in,
    // Status
    output var  logic load_start_out,
    output var  logic loaded_out
);

    localparam int unsigned CNT_W = $clog2(INTERVAL + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(INTERVAL - 1);

    logic [CNT_W-1:0] count;
    wire              active = standalone_in && !loaded_out && !load_done_in;
    wire              fire   = active && (count == '0);

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count          <= '0;
            load_start_out <= 1'b0;
            loaded_out     <= 1'b0;
        end else begin
            // Leaving standalone mode stops attempts and rearms the timer.
            if (!active) begin
                count <= '0;
            end else if (fire) begin
                count <= LAST;
            end else begin
                count <= count - 1'b1;
            end
            load_start_out <= fire;
            if (load_done_in) begin
                loaded_out <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [dscr_sync.sv]
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clock_in.
`timescale 1ns/1ns
`default_nettype none
module dscr_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the register bank with a loader model on its load port.
// Assumes command accesses answered one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int unsigned RI = 20;
    localparam logic [7:0] CODES [22] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0D, 8'h10, 8'h11,
        8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h1F};
    logic clock_in, nrst_in, cmd_write_in, cmd_read_in, load_write_in, load_busy_in, load_done_in;
    logic tx_enable_pin_in, cmd_ack_out, cmd_nack_out, load_start_out, loaded_out, present;
    logic external_control_out, tx_enable_out, hs_amp_off_out, apc_mode_out;
    logic ext_temp_sel_out, photodiode_orientation_out, cml_term_out;
    logic [7:0]  cmd_code_in, load_code_in;
    logic [15:0] cmd_wdata_in, cmd_rdata_out, load_wdata_in, fault_flags_in, power_limit_in, comp_temperature_out;
    int fails = 0;
    int checked = 0;
    dscr_regs #(.RETRY_INTERVAL(RI)) DUT (.*);
    dscr_loader_model u_eeprom (.clock_in, .nrst_in, .load_start_in(load_start_out), .present_in(present),
        .word_in(16'h00E4), .load_code_out(load_code_in), .load_write_out(load_write_in),
        .load_wdata_out(load_wdata_in), .load_busy_out(load_busy_in), .load_done_out(load_done_in));
    task automatic test_done();
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic bound(input int i);
        if (i >= 100) begin
            fails++;
            test_done();
        end
    endtask
    // Entered at a falling edge; the strobe is held over exactly one rising edge.
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data, input logic [1:0] exp);
        cmd_code_in = code;
        cmd_wdata_in = data;
        cmd_write_in = wr;
        cmd_read_in = !wr;
        tick(1);
        // The answer stands for one cycle only, so it is looked at before the next rising edge.
        chk({cmd_ack_out, cmd_nack_out}, exp);
        cmd_write_in = 1'b0;
        cmd_read_in = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        access(1'b0, code, 16'h0000, 2'b10);
        chk(cmd_rdata_out, exp);
    endtask
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        int i;
        int n;
        logic [15:0] v;
        {nrst_in, cmd_write_in, cmd_read_in, cmd_code_in, cmd_wdata_in, present} = '0;
        tx_enable_pin_in = 1'b1;
        fault_flags_in = 16'h5A3C;
        power_limit_in = 16'h0F0F;
        tick(16);
        nrst_in = 1'b1;
        for (i = 0; i < 100 && load_start_out !== 1'b1; i++) tick(1);
        bound(i);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (load_start_out !== 1'b1 && n < 100);
        chk(n, RI);
        tick(8);
        rd(8'h10, 16'h0010);
        rd(8'h1E, 16'h0021);
        rd(8'h1F, 16'h0010);
        present = 1'b1;
        for (i = 0; i < 100 && load_busy_in !== 1'b1; i++) tick(1);
        bound(i);
        access(1'b0, 8'h10, 16'h0000, 2'b01);
        for (i = 0; i < 100 && loaded_out !== 1'b1; i++) tick(1);
        bound(i);
        rd(8'h10, 16'h00E4);
        rd(8'h1E, 16'h0055);
        chk({external_control_out, cml_term_out, photodiode_orientation_out, ext_temp_sel_out, apc_mode_out},
            5'b01110);
        for (i = 0; i < 22; i++) begin
            v = {CODES[i], ~CODES[i]};
            if (CODES[i] == 8'h12 || CODES[i] == 8'h03) begin
                access(1'b1, CODES[i], v, 2'b01);
                rd(CODES[i], CODES[i] == 8'h12 ? fault_flags_in : power_limit_in);
            end else if (CODES[i] != 8'h10) begin
                access(1'b1, CODES[i], v, 2'b10);
                rd(CODES[i], v);
            end
        end
        access(1'b1, 8'h04, 16'h1234, 2'b01);
        access(1'b0, 8'h20, 16'h0000, 2'b01);
        tick(2);
        chk(comp_temperature_out, 16'h0DF2);
        access(1'b1, 8'h10, 16'hFF13, 2'b10);
        rd(8'h10, 16'h0013);
        chk(external_control_out, 1'b1);
        tx_enable_pin_in = 1'b0;
        tick(4);
        chk({tx_enable_out, hs_amp_off_out}, 2'b10);
        tx_enable_pin_in = 1'b1;
        tick(4);
        chk({tx_enable_out, hs_amp_off_out}, 2'b01);
        access(1'b1, 8'h10, 16'h0007, 2'b10);
        tick(2);
        chk({tx_enable_out, hs_amp_off_out}, 2'b10);
        tx_enable_pin_in = 1'b0;
        tick(4);
        chk({tx_enable_out, hs_amp_off_out}, 2'b00);
        tx_enable_pin_in = 1'b1;
        access(1'b1, 8'h10, 16'h0015, 2'b10);
        tick(4);
        chk({tx_enable_out, hs_amp_off_out}, 2'b01);
        for (i = 0; i < 4; i++) begin
            n = (i == 0) ? 3 : i + 4;
            access(1'b1, 8'h10, 16'h0001 | (16'h0001 << n), 2'b10);
            tick(2);
            chk({cml_term_out, photodiode_orientation_out, ext_temp_sel_out, apc_mode_out}, 4'h1 << i);
        end
        chk(comp_temperature_out, 16'h05FA);
        access(1'b1, 8'h05, 16'h1234, 2'b10);
        tick(1);
        chk(comp_temperature_out, 16'h1234);
        test_done();
    end
endmodule
`default_nettype wire
